// ### rtl/sfw_pkg.sv
// Shared constants and types for the serial flash write/erase control ends
package sfw_pkg;
	// ==========================================================
	// Command opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_SSE = 8'h20;
	localparam logic [7:0] OP_SE = 8'hd8;
	localparam logic [7:0] OP_DIE = 8'hc4;
	localparam logic [7:0] OP_BE = 8'hc7;
	localparam logic [7:0] OP_CLFS = 8'h50;
	localparam logic [7:0] OP_RDFS = 8'h70;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESM = 8'h7a;
	// ==========================================================
	// Framing
	localparam logic [5:0] OP_BITS = 6'h08;
	localparam logic [5:0] OPADDR_BITS = 6'h20;
	localparam int SECTOR_MSB = 23;
	localparam int SECTOR_LSB = 16;
	// ==========================================================
	// Flag status and status bit positions, reset values
	localparam int FS_READY = 7;
	localparam int FS_ESUSP = 6;
	localparam int FS_EERR = 5;
	localparam int FS_PERR = 4;
	localparam int FS_PROT = 1;
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam logic [7:0] FLAGS_RESET = 8'h80;
	// ==========================================================
	// Timing in pclk cycles
	localparam int SCLK_HALF = 8;
	localparam int SSE_CYC = 200;
	localparam int SE_CYC = 400;
	localparam int DIE_CYC = 800;
	localparam int BE_CYC = 1600;
	// ==========================================================
	// Host register map and command fields
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0c;
	localparam int CMD_ADDR_BIT = 8;
	localparam int CMD_READ_BIT = 9;
	localparam int CMD_EXTRA_BIT = 10;
	localparam int STAT_RX_LSB = 8;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {PR_EXT = 2'b00, PR_DUAL = 2'b01, PR_QUAD = 2'b10} sfw_proto_e;
	typedef enum logic [1:0] {EK_SSE = 2'b00, EK_SE = 2'b01, EK_DIE = 2'b10, EK_BE = 2'b11} sfw_kind_e;

	// Bits moved per serial clock; protocol code is its log2
	function automatic logic [5:0] sfw_width(input sfw_proto_e p);
		sfw_width = 6'h01 << p;
	endfunction
endpackage

// ### rtl/sfw_if.sv
// Serial link between flash controller and flash write/erase logic
`timescale 1ns/1ps
`default_nettype none
interface sfw_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_dq_o;
	logic [3:0] host_dq_oe;
	logic [3:0] dev_dq_o;
	logic [3:0] dev_dq_oe;
	logic [3:0] dq;

	// Resolved lane level; undriven lanes idle high as with pull-ups
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dq[i] = host_dq_oe[i] ? host_dq_o[i] : (dev_dq_oe[i] ? dev_dq_o[i] : 1'b1);
		end
	end

	modport host (output cs_n, output sclk, output host_dq_o, output host_dq_oe, input dq);
	modport dev (input cs_n, input sclk, output dev_dq_o, output dev_dq_oe, input dq);
endinterface
`default_nettype wire

// ### rtl/sfw_host.sv
// Flash controller end: APB registers in, serial frames out
`timescale 1ns/1ps
`default_nettype none
module sfw_host import sfw_pkg::*; #(
	parameter int HALF = SCLK_HALF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link and protocol choice shared with the device
	sfw_if.host link,
	output sfw_proto_e link_proto
);
	typedef enum logic [2:0] {H_IDLE = 3'b000, H_LOW = 3'b001, H_HIGH = 3'b010,
		H_TAIL = 3'b011, H_GAP = 3'b100} sfw_hstate_e;

	sfw_hstate_e hs;
	logic [23:0] addr_reg;
	logic [7:0] rx_byte;
	logic [31:0] tx;
	logic [31:0] tx_next;
	logic [5:0] left;
	logic [5:0] rdc;
	logic rd_en;
	logic [3:0] dq_s1;
	logic [3:0] dq_s2;
	logic [7:0] div;
	logic tick;
	logic wr_acc;
	logic start;
	logic [5:0] w;
	logic [3:0] lane_mask;

	assign tick = (div == 8'(HALF - 1));
	assign wr_acc = psel & penable & pready & pwrite;
	assign start = wr_acc && (paddr == REG_CMD) && (hs == H_IDLE);
	assign w = sfw_width(link_proto);
	assign lane_mask = 4'((6'h01 << w) - 6'h01);
	// Next bits come from the shifted word so narrow lanes see each opcode bit in turn
	assign tx_next = tx << w;

	// ==========================================================
	// APB: one wait state so read data leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			addr_reg <= 24'h00_0000;
			link_proto <= PR_EXT;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel && penable && !pready) begin
				pslverr <= !(paddr inside {REG_CMD, REG_ADDR, REG_STAT, REG_CFG});
				unique case (paddr)
					REG_ADDR: prdata <= {8'h00, addr_reg};
					REG_STAT: prdata <= {16'h0000, rx_byte, 7'h00, hs != H_IDLE};
					REG_CFG: prdata <= {30'h0, link_proto};
					default: prdata <= 32'h0000_0000;
				endcase
			end
			if (wr_acc && paddr == REG_ADDR) begin
				addr_reg <= pwdata[23:0];
			end
			// A CFG write while a frame runs would garble it, so it is dropped unless idle
			if (wr_acc && paddr == REG_CFG && hs == H_IDLE && pwdata[1:0] != 2'b11) begin
				link_proto <= sfw_proto_e'(pwdata[1:0]);
			end
		end
	end

	// ==========================================================
	// Half-period divider, running from frame start through the select gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 8'h00;
		end else if (hs == H_IDLE || tick) begin
			div <= 8'h00;
		end else begin
			div <= div + 8'h01;
		end
	end

	// Lane synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_s1 <= 4'hf;
			dq_s2 <= 4'hf;
		end else begin
			dq_s1 <= link.dq;
			dq_s2 <= dq_s1;
		end
	end

	// ==========================================================
	// Frame sequencer: data set while sclk low, device takes it on the rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs <= H_IDLE;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.host_dq_o <= 4'h0;
			link.host_dq_oe <= 4'h0;
			tx <= 32'h0000_0000;
			left <= 6'h00;
			rdc <= 6'h00;
			rd_en <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			unique case (hs)
				H_IDLE: begin
					if (start) begin
						hs <= H_LOW;
						link.cs_n <= 1'b0;
						rd_en <= pwdata[CMD_READ_BIT];
						rdc <= pwdata[CMD_READ_BIT] ? (OP_BITS >> link_proto) : 6'h00;
						// Extra clock only exists to exercise a misframed command
						left <= ((pwdata[CMD_ADDR_BIT] ? OPADDR_BITS : OP_BITS) >> link_proto)
							+ (pwdata[CMD_READ_BIT] ? (OP_BITS >> link_proto) : 6'h00)
							+ {5'h00, pwdata[CMD_EXTRA_BIT]};
						tx <= pwdata[CMD_ADDR_BIT] ? {pwdata[7:0], addr_reg}
							: {pwdata[7:0], 24'h00_0000};
						link.host_dq_o <= (pwdata[7:4] >> (6'h04 - w)) & lane_mask;
						link.host_dq_oe <= lane_mask;
					end
				end
				H_LOW: begin
					if (tick) begin
						link.sclk <= 1'b1;
						hs <= H_HIGH;
						if (rd_en && left <= rdc) begin
							rx_byte <= (link_proto == PR_EXT) ? {rx_byte[6:0], dq_s2[1]}
								: 8'((rx_byte << w) | {4'h0, dq_s2 & lane_mask});
						end
						left <= left - 6'h01;
					end
				end
				H_HIGH: begin
					if (tick) begin
						link.sclk <= 1'b0;
						if (left == 6'h00) begin
							hs <= H_TAIL;
						end else begin
							hs <= H_LOW;
							tx <= tx_next;
							link.host_dq_o <= (tx_next[31:28] >> (6'h04 - w)) & lane_mask;
							if (left <= rdc) begin
								link.host_dq_oe <= 4'h0;
							end
						end
					end
				end
				H_TAIL: begin
					// Select rises only after the final bit was taken
					if (tick) begin
						link.cs_n <= 1'b1;
						link.host_dq_oe <= 4'h0;
						hs <= H_GAP;
					end
				end
				H_GAP: begin
					if (tick) begin
						hs <= H_IDLE;
					end
				end
				default: hs <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### rtl/sfw_dev.sv
// Flash end: write-enable latch, flag status and self-timed erase engine
//
// Behaviour
// - 06h sets latch, 04h clears it
// - Latch commands on one, two or four lanes
// - Select must rise right after eighth bit
// - Latch required before erase commands
// - Protection error blocks disable; flag clear clears
// - Ready bit low while erasing, high after
// - Accepted erase start clears the latch
// - Subsector erase: opcode, address, starts on select
// - Sector erase: same framing, whole sector
// - Die erase: address picks whole die
// - Latch clear: erase ignored, no flags
// - Erase timeout resets latch, sets error
// - Misframed erase: nothing executes, latch kept
// - Protected target: refuse, set bits 1, 5
// - Die/bulk refused when any sector locked
// - Bulk erase: lone opcode, reset-pin variants
// - Bulk erase shows write-in-progress until done
// - Sector/subsector erase can suspend and resume
// - Address phase length scales with lanes
// - Bits captured on serial clock rise
// - Bit 4 program error; flag clear clears
`timescale 1ns/1ps
`default_nettype none
module sfw_dev import sfw_pkg::*; #(
	parameter int SSE_CYCLES = SSE_CYC,
	parameter int SE_CYCLES = SE_CYC,
	parameter int DIE_CYCLES = DIE_CYC,
	parameter int BE_CYCLES = BE_CYC,
	parameter bit HAS_RESET_PIN = 1'b1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	sfw_if.dev link,
	// Configuration
	input wire sfw_proto_e proto,
	input wire logic [255:0] sector_lock,
	input wire logic force_timeout,
	// State seen by the array side
	output logic wel,
	output logic wip,
	output logic [7:0] flags,
	output logic [23:0] erase_addr,
	output sfw_kind_e erase_kind
);
	typedef enum logic [1:0] {ES_IDLE = 2'b00, ES_RUN = 2'b01, ES_SUSP = 2'b10} sfw_estate_e;
	sfw_estate_e est;
	logic [31:0] timer, shreg, next_sh;
	logic cs_s1, cs_s2, cs_s3;
	logic sck_s1, sck_s2, sck_s3;
	logic [3:0] dq_s1, dq_s2;
	logic [5:0] bitcnt, next_cnt;
	logic cs_rise, cs_fall, sck_rise, sck_fall;
	logic rd_on, rd_flags, er_req, er_locked;
	logic [7:0] osh, cur;
	logic [2:0] ocnt;
	sfw_kind_e er_kind;
	// Load value for each erase size
	function automatic logic [31:0] erase_cycles(input sfw_kind_e k);
		unique case (k)
			EK_SSE: erase_cycles = 32'(SSE_CYCLES);
			EK_SE: erase_cycles = 32'(SE_CYCLES);
			EK_DIE: erase_cycles = 32'(DIE_CYCLES);
			EK_BE: erase_cycles = 32'(BE_CYCLES);
		endcase
	endfunction

	// ==========================================================
	// Pin synchronisers; edges are judged on the second and third stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cs_s1, cs_s2, cs_s3} <= 3'b111;
			{sck_s1, sck_s2, sck_s3} <= 3'b000;
			dq_s1 <= 4'hf;
			dq_s2 <= 4'hf;
		end else begin
			{cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
			{sck_s1, sck_s2, sck_s3} <= {link.sclk, sck_s1, sck_s2};
			dq_s1 <= link.dq;
			dq_s2 <= dq_s1;
		end
	end

	assign cs_rise = cs_s2 & ~cs_s3;
	assign cs_fall = ~cs_s2 & cs_s3;
	assign sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_s3 & ~cs_s2;

	// Next shift contents, lanes taken MSB first
	always_comb begin
		unique case (proto)
			PR_DUAL: next_sh = {shreg[29:0], dq_s2[1:0]};
			PR_QUAD: next_sh = {shreg[27:0], dq_s2[3:0]};
			default: next_sh = {shreg[30:0], dq_s2[0]};
		endcase
		// Saturates so an overlong frame never aliases back to a legal count
		next_cnt = (bitcnt < 6'h28) ? bitcnt + sfw_width(proto) : bitcnt;
	end

	// ==========================================================
	// Input shifter: opcode and address bits on each serial rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg <= 32'h0000_0000;
			bitcnt <= 6'h00;
		end else if (cs_fall) begin
			shreg <= 32'h0000_0000;
			bitcnt <= 6'h00;
		end else if (sck_rise) begin
			shreg <= next_sh;
			bitcnt <= next_cnt;
		end
	end

	// ==========================================================
	// Status output: byte repeats while select stays low
	assign cur = (ocnt == 3'h0) ? (rd_flags ? flags : {6'h00, wel, wip}) : osh;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_on <= 1'b0;
			rd_flags <= 1'b0;
			osh <= 8'h00;
			ocnt <= 3'h0;
			link.dev_dq_o <= 4'h0;
			link.dev_dq_oe <= 4'h0;
		end else if (cs_s2) begin
			rd_on <= 1'b0;
			link.dev_dq_oe <= 4'h0;
		end else if (sck_rise && next_cnt == OP_BITS
			&& (next_sh[7:0] == OP_RDFS || next_sh[7:0] == OP_RDSR)) begin
			rd_on <= 1'b1;
			rd_flags <= (next_sh[7:0] == OP_RDFS);
			ocnt <= 3'h0;
		end else if (sck_fall && rd_on) begin
			// Flags are sampled fresh at each byte boundary so polling sees completion
			osh <= 8'(cur << sfw_width(proto));
			ocnt <= ocnt + 3'(sfw_width(proto));
			unique case (proto)
				PR_DUAL: begin
					link.dev_dq_o <= {2'b00, cur[7:6]};
					link.dev_dq_oe <= 4'h3;
				end
				PR_QUAD: begin
					link.dev_dq_o <= cur[7:4];
					link.dev_dq_oe <= 4'hf;
				end
				default: begin
					link.dev_dq_o <= {2'b00, cur[7], 1'b0};
					link.dev_dq_oe <= 4'h2;
				end
			endcase
		end
	end

	// ==========================================================
	// Erase request decode at select rise; wrong bit counts never match
	always_comb begin
		er_req = 1'b0;
		er_kind = EK_SSE;
		er_locked = 1'b0;
		if (cs_rise && bitcnt == OPADDR_BITS) begin
			unique case (shreg[31:24])
				OP_SSE, OP_SE: begin
					er_req = 1'b1;
					er_kind = (shreg[31:24] == OP_SE) ? EK_SE : EK_SSE;
					er_locked = sector_lock[shreg[SECTOR_MSB:SECTOR_LSB]];
				end
				OP_DIE: begin
					er_req = 1'b1;
					er_kind = EK_DIE;
					er_locked = |sector_lock;
				end
				default: er_req = 1'b0;
			endcase
		end else if (cs_rise && bitcnt == OP_BITS && shreg[7:0] == OP_BE && HAS_RESET_PIN) begin
			er_req = 1'b1;
			er_kind = EK_BE;
			er_locked = |sector_lock;
		end
	end

	// ==========================================================
	// Latch, flags and erase engine; completion is written last so
	// its flag sets win over a clear arriving in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wel <= 1'b0;
			wip <= 1'b0;
			flags <= FLAGS_RESET;
			est <= ES_IDLE;
			timer <= 32'h0000_0000;
			erase_addr <= 24'h00_0000;
			erase_kind <= EK_SSE;
		end else begin
			if (cs_rise && bitcnt == OP_BITS) begin
				unique case (shreg[7:0])
					OP_WREN: begin
						if (est != ES_RUN) begin
							wel <= 1'b1;
						end
					end
					OP_WRDI: begin
						if (est != ES_RUN && !flags[FS_PROT]) begin
							wel <= 1'b0;
						end
					end
					OP_CLFS: begin
						if (est != ES_RUN) begin
							flags[FS_EERR] <= 1'b0;
							flags[FS_PERR] <= 1'b0;
							flags[FS_PROT] <= 1'b0;
							wel <= 1'b0;
						end
					end
					OP_SUSP: begin
						if (est == ES_RUN && erase_kind inside {EK_SSE, EK_SE}) begin
							est <= ES_SUSP;
							flags[FS_ESUSP] <= 1'b1;
							flags[FS_READY] <= 1'b1;
							wip <= 1'b0;
						end
					end
					OP_RESM: begin
						if (est == ES_SUSP) begin
							est <= ES_RUN;
							flags[FS_ESUSP] <= 1'b0;
							flags[FS_READY] <= 1'b0;
							wip <= 1'b1;
						end
					end
					default: est <= est;
				endcase
			end
			// Without the latch the request vanishes with no trace
			if (er_req && wel && est == ES_IDLE) begin
				if (er_locked) begin
					flags[FS_PROT] <= 1'b1;
					flags[FS_EERR] <= 1'b1;
				end else begin
					wel <= 1'b0;
					wip <= 1'b1;
					flags[FS_READY] <= 1'b0;
					est <= ES_RUN;
					timer <= erase_cycles(er_kind);
					erase_kind <= er_kind;
					erase_addr <= shreg[23:0];
				end
			end
			if (est == ES_RUN) begin
				if (timer == 32'h0000_0000) begin
					// A late suspend loses to completion
					est <= ES_IDLE;
					wip <= 1'b0;
					flags[FS_READY] <= 1'b1;
					flags[FS_ESUSP] <= 1'b0;
					if (force_timeout) begin
						wel <= 1'b0;
						flags[FS_EERR] <= 1'b1;
					end
				end else if (!(cs_rise && bitcnt == OP_BITS && shreg[7:0] == OP_SUSP)) begin
					timer <= timer - 32'h0000_0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/sfw_properties.sv
// Concurrent checks on the serial link and the flash end state
`timescale 1ns/1ps
`default_nettype none
module sfw_properties import sfw_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] host_dq_o,
	input wire logic [3:0] host_dq_oe,
	input wire logic [3:0] dev_dq_oe,
	// Flash end state
	input wire logic wel,
	input wire logic wip,
	input wire logic [7:0] flags
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Cycles since select rose, saturating; commands act only then
	logic cs_q;
	logic [3:0] since_rise;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_q <= 1'b1;
			since_rise <= 4'hf;
		end else begin
			cs_q <= cs_n;
			if (cs_n && !cs_q) begin
				since_rise <= 4'h0;
			end else if (since_rise != 4'hf) begin
				since_rise <= since_rise + 4'h1;
			end
		end
	end
	// ==========================================================
	// Clock high phase lasts exactly one half period
	sequence s_high_half;
		sclk [*8] ##1 !sclk;
	endsequence
	sequence s_start;
		$rose(wip);
	endsequence
	chk_wel_at_select: assert property ($changed(wel) |-> since_rise <= 4'h8)
		else $error("latch moved away from a select rise");
	chk_erase_at_select: assert property (s_start |-> cs_n && since_rise <= 4'h8)
		else $error("erase began away from a select rise");
	chk_start_drops_wel: assert property (s_start |-> ##[0:1] !wel)
		else $error("latch still set after erase start");
	chk_busy_not_ready: assert property (wip |-> !flags[FS_READY])
		else $error("ready flag high while busy");
	chk_done_ready: assert property ($fell(wip) |-> ##[0:1] (flags[FS_READY] || flags[FS_ESUSP]))
		else $error("ready flag not restored when busy fell");
	chk_prot_keeps_wel: assert property ($rose(flags[FS_PROT]) |-> ##[0:1] (wel && flags[FS_EERR]))
		else $error("protection error without latch or erase error");
	chk_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	chk_sclk_half: assert property ($rose(sclk) |-> s_high_half)
		else $error("serial clock high phase wrong length");
	chk_lanes_held: assert property (sclk |-> $stable(host_dq_o) && $stable(host_dq_oe))
		else $error("host lanes moved while clock high");
	chk_no_contention: assert property (!(|(host_dq_oe & dev_dq_oe)))
		else $error("both ends drive one lane");
endmodule
`default_nettype wire

// ### dv/sfw_tb.sv
// Self-checking bench joining controller and flash ends over the link
`timescale 1ns/1ps
`default_nettype none
module sfw_tb import sfw_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, force_timeout;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [255:0] sector_lock;
	sfw_proto_e link_proto;
	sfw_kind_e erase_kind;
	logic wel, wip, err;
	logic [7:0] flags;
	logic [23:0] erase_addr;
	logic [31:0] seen;
	int num_errors, checked, cycles, edges;
	// ==========================================================
	// Two ends facing each other
	sfw_if link_if();
	sfw_host sfw_host_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_if), .link_proto(link_proto));
	sfw_dev #(.SSE_CYCLES(300), .SE_CYCLES(600), .DIE_CYCLES(300), .BE_CYCLES(300)) sfw_dev_i(
		.pclk(pclk), .presetn(presetn), .link(link_if), .proto(link_proto),
		.sector_lock(sector_lock), .force_timeout(force_timeout), .wel(wel), .wip(wip),
		.flags(flags), .erase_addr(erase_addr), .erase_kind(erase_kind));
	sfw_properties sfw_properties_i(.pclk(pclk), .presetn(presetn), .cs_n(link_if.cs_n),
		.sclk(link_if.sclk), .host_dq_o(link_if.host_dq_o), .host_dq_oe(link_if.host_dq_oe),
		.dev_dq_oe(link_if.dev_dq_oe), .wel(wel), .wip(wip), .flags(flags));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Lane monitor: clocks per frame and last lane nibbles
	// One process owns the counter; select fall clears it, clock rise counts
	always @(negedge link_if.cs_n or posedge link_if.sclk) begin
		if (link_if.sclk) begin
			edges++;
			seen = {seen[27:0], link_if.dq};
		end else begin
			edges = 0;
		end
	end
	// Watchdog; well above the roughly 13k cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			complete_run();
		end
	end
	// ==========================================================
	// Common tasks
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Whole frame, then the select gap; rd[15:8] holds any byte read
	task automatic frame(input logic [10:0] cmd, input logic [23:0] a);
		apb(1'b1, REG_ADDR, {8'h00, a});
		apb(1'b1, REG_CMD, {21'h0, cmd});
		do apb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
		repeat (16) @(posedge pclk);
	endtask
	task automatic wait_done();
		do frame({3'b010, OP_RDFS}, 24'h0); while (rd[15] !== 1'b1);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_latch();
		for (int p = 0; p < 3; p++) begin
			apb(1'b1, REG_CFG, p);
			frame({3'b000, OP_WREN}, 24'h0);
			chk("wel set", 32'h1, {31'h0, wel});
			chk("opcode clocks", 8 >> p, edges);
			if (p == 2) chk("quad lanes", 32'h06, {24'h0, seen[7:0]});
			frame({3'b010, OP_RDSR}, 24'h0);
			chk("status byte", 32'h02, {24'h0, rd[15:8]});
			frame({3'b000, OP_WRDI}, 24'h0);
			chk("wel cleared", 32'h0, {31'h0, wel});
		end
		apb(1'b1, REG_CFG, 32'h0);
	endtask
	task automatic t_misframe();
		frame({3'b100, OP_WREN}, 24'h0);
		chk("wel long enable", 32'h0, {31'h0, wel});
		frame({3'b000, OP_WREN}, 24'h0);
		frame({3'b101, OP_SE}, 24'h010000);
		chk("busy long erase", 32'h0, {31'h0, wip});
		chk("flags long erase", 32'h80, {24'h0, flags});
		chk("wel long erase", 32'h1, {31'h0, wel});
		frame({3'b000, OP_WRDI}, 24'h0);
		frame({3'b001, OP_SE}, 24'h010000);
		chk("busy no latch", 32'h0, {31'h0, wip});
		chk("flags no latch", 32'h80, {24'h0, flags});
	endtask
	task automatic t_erase();
		logic [7:0] ops [4] = '{OP_SSE, OP_SE, OP_DIE, OP_BE};
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, REG_CFG, k % 3);
			frame({3'b000, OP_WREN}, 24'h0);
			frame({2'b00, k < 3, ops[k]}, 24'(24'h123456 + k));
			chk("erase clocks", (k < 3 ? 32 : 8) >> (k % 3), edges);
			chk("wel at start", 32'h0, {31'h0, wel});
			chk("busy at start", 32'h1, {31'h0, wip});
			chk("erase kind", k, {30'h0, erase_kind});
			if (k < 3) chk("erase addr", 32'h123456 + k, {8'h0, erase_addr});
			wait_done();
			chk("busy at end", 32'h0, {31'h0, wip});
			chk("flags at end", 32'h80, {24'h0, rd[15:8]});
		end
		apb(1'b1, REG_CFG, 32'h0);
	endtask
	task automatic t_protect();
		logic [10:0] cmds [3] = '{{3'b001, OP_SE}, {3'b001, OP_DIE}, {3'b000, OP_BE}};
		sector_lock[18] <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			frame({3'b000, OP_WREN}, 24'h0);
			frame(cmds[k], 24'h12abcd);
			chk("flags locked", 32'ha2, {24'h0, flags});
			chk("wel locked", 32'h1, {31'h0, wel});
			frame({3'b000, OP_WRDI}, 24'h0);
			chk("wel kept", 32'h1, {31'h0, wel});
			frame({3'b000, OP_CLFS}, 24'h0);
			chk("wel cleared", 32'h0, {31'h0, wel});
			chk("flags cleared", 32'h80, {24'h0, flags});
		end
		sector_lock <= '0;
	endtask
	task automatic t_timeout();
		force_timeout <= 1'b1;
		frame({3'b000, OP_WREN}, 24'h0);
		frame({3'b001, OP_SSE}, 24'h001000);
		wait_done();
		chk("flags timeout", 32'ha0, {24'h0, rd[15:8]});
		chk("wel timeout", 32'h0, {31'h0, wel});
		force_timeout <= 1'b0;
		frame({3'b000, OP_CLFS}, 24'h0);
	endtask
	task automatic t_suspend();
		frame({3'b000, OP_WREN}, 24'h0);
		frame({3'b001, OP_SE}, 24'h020000);
		frame({3'b000, OP_SUSP}, 24'h0);
		chk("busy suspended", 32'h0, {31'h0, wip});
		chk("suspend flag", 32'h1, {31'h0, flags[FS_ESUSP]});
		frame({3'b000, OP_RESM}, 24'h0);
		chk("busy resumed", 32'h1, {31'h0, wip});
		wait_done();
		chk("flags resumed", 32'h80, {24'h0, rd[15:8]});
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sector_lock = '0;
		force_timeout = 1'b0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk("flags reset", 32'h80, {24'h0, flags});
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		t_latch();
		t_misframe();
		t_erase();
		t_protect();
		t_timeout();
		t_suspend();
		complete_run();
	end
endmodule
`default_nettype wire
